// File: vdfc_pkg.sv
// vdfc_pkg: constants and carrier types for the front control registers
// assumes: byte-wide register port, subaddresses 00h..02h
package vdfc_pkg;
  localparam logic [7:0] SUB_VERSION     = 8'h00;
  localparam logic [7:0] SUB_HDELAY_PEAK = 8'h01;
  localparam logic [7:0] SUB_ANALOG_IN   = 8'h02;
  localparam int VERSION_LSB = 4;
  localparam int WPD_BIT     = 6;
  localparam int HYST_LSB    = 4;
  localparam int HORIZONTAL_INCREMENT_DELAY_LSB    = 0;
  localparam int ANALOG_FUNCTION_SELECT_LSB    = 6;
  localparam int MODE_LSB    = 0;
  localparam logic [7:0] HDELAY_PEAK_RST = 8'h07;
  localparam logic [7:0] ANALOG_IN_RST   = 8'h00;
  localparam logic [3:0] HORIZONTAL_INCREMENT_DELAY_HOLD       = 4'hF;
  localparam logic [3:0] HORIZONTAL_INCREMENT_DELAY_MIN        = 4'hE;
  localparam logic [8:0] WHITE_NOMINAL   = 9'h0EB;
  localparam logic [5:0] MODE_YC_LAST    = 6'h0D;

  typedef struct packed {
    logic       wr;
    logic [7:0] sub;
    logic [7:0] wdata;
  } vdfc_req_t;

  typedef struct packed {
    logic       white_limit_on;
    logic [1:0] gain_update_hysteresis;
    logic [3:0] horizontal_increment_delay;
    logic       amp_on;
    logic       aaf_on;
    logic       ch_is_yc;
    logic       chroma_follows_luma;
    logic [2:0] luma_input;
    logic [2:0] chroma_input;
    logic       mode_valid;
  } vdfc_ctrl_t;
endpackage : vdfc_pkg

// File: vdfc_mode_decode.sv
// vdfc_mode_decode: decodes analog function and input mode fields
// assumes: pure combinational, fed from register flops of the same clock
`timescale 1ns/100ps
module vdfc_mode_decode (
  input  wire logic [1:0] analog_function_select,
  input  wire logic [5:0] mode,
  output logic            amp_on,
  output logic            aaf_on,
  output logic            yc,
  output logic            follow,
  output logic [2:0]      luma_in,
  output logic [2:0]      chroma_in,
  output logic            valid
);
  // input index: 0..5 = 11,12,21,22,23,24 ; 6,7 = 13,14
  always_comb begin
    amp_on    = analog_function_select[1];
    aaf_on    = (analog_function_select == 2'b11);
    yc        = 1'b0;
    follow    = 1'b0;
    luma_in   = 3'd0;
    chroma_in = 3'd0;
    valid     = 1'b1;
    if (mode <= 6'h05) begin
      luma_in = mode[2:0];
    end else if (mode <= vdfc_pkg::MODE_YC_LAST) begin
      yc     = 1'b1;
      follow = mode[3] & ~mode[1];
      unique case (mode)
        6'h06, 6'h08: begin luma_in = 3'd0; chroma_in = 3'd2; end
        6'h07, 6'h09: begin luma_in = 3'd1; chroma_in = 3'd3; end
        6'h0A, 6'h0C: begin luma_in = 3'd6; chroma_in = 3'd4; end
        default:      begin luma_in = 3'd7; chroma_in = 3'd5; end
      endcase
    end else begin
      // other modes belong to a later slice
      valid = 1'b0;
    end
  end
endmodule : vdfc_mode_decode

// File: vdfc_front_control_regs.sv
// vdfc_front_control_regs: subaddress 00h..02h control registers
// assumes: byte write/read strobes from the two-wire bus slave, one clock
// Overview of operation
// - subaddress 00h upper nibble reads a fixed version code, writes ignored.
// - bit 6 of 01h at zero enables white limiting, at one disables it.
// - while limiting is on, converter input is attenuated above nominal white.
// - bits 5:4 of 01h set gain update hysteresis of 0 to 3 LSB.
// - bits 3:0 of 01h set increment delay, 1110 least, 0000 most, 1111 holds.
// - bits 7:6 of 02h bypass amp and filter for 0x, amp only 10, both 11.
// - modes 00h..05h pick composite with auto gain from 11,12,21,22,23,24.
// - modes 06h,07h,0Ah,0Bh are luma/chroma with programmed chroma gain.
// - modes 08h,09h,0Ch,0Dh are luma/chroma with chroma gain following luma.
// - pairs are 11/21, 12/22, 13/23 and 14/24.
`timescale 1ns/100ps
module vdfc_front_control_regs #(
  parameter logic [3:0] SILICON_REVISION = 4'h1 // arbitrary value
) (
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  input  wire vdfc_pkg::vdfc_req_t   req,
  input  wire logic                  req_valid,
  input  wire logic [8:0]            luma_level,
  output logic [7:0]                 rdata,
  output logic                       rdata_valid,
  output logic                       attenuate,
  output vdfc_pkg::vdfc_ctrl_t       ctrl
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] hdelay_peak;
  logic [7:0] analog_in;
  logic [3:0] horizontal_increment_delay_applied;
  logic       amp_on, aaf_on, yc, follow, valid;
  logic [2:0] luma_in, chroma_in;
  logic       wr_hd, wr_ai;

  assign wr_hd = req_valid & req.wr & (req.sub == vdfc_pkg::SUB_HDELAY_PEAK);
  assign wr_ai = req_valid & req.wr & (req.sub == vdfc_pkg::SUB_ANALOG_IN);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hdelay_peak <= vdfc_pkg::HDELAY_PEAK_RST;
    end else if (wr_hd) begin
      hdelay_peak <= {1'b0, req.wdata[6:0]};
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      analog_in <= vdfc_pkg::ANALOG_IN_RST;
    end else if (wr_ai) begin
      analog_in <= req.wdata;
    end
  end

  // code 1111 keeps the previous delay so timing is not disturbed
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      horizontal_increment_delay_applied <= vdfc_pkg::HDELAY_PEAK_RST[3:0];
    end else if (wr_hd && req.wdata[3:0] != vdfc_pkg::HORIZONTAL_INCREMENT_DELAY_HOLD) begin
      horizontal_increment_delay_applied <= req.wdata[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata       <= 8'h00;
      rdata_valid <= 1'b0;
    end else begin
      rdata_valid <= req_valid & ~req.wr;
      if (req_valid && !req.wr) begin
        unique case (req.sub)
          vdfc_pkg::SUB_VERSION:     rdata <= {SILICON_REVISION, 4'h0};
          vdfc_pkg::SUB_HDELAY_PEAK: rdata <= hdelay_peak;
          vdfc_pkg::SUB_ANALOG_IN:   rdata <= analog_in;
          default:                   rdata <= 8'h00;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  vdfc_mode_decode u_dec (
    .analog_function_select (analog_in[7:6]),
    .mode                   (analog_in[5:0]),
    .amp_on                 (amp_on),
    .aaf_on                 (aaf_on),
    .yc                     (yc),
    .follow                 (follow),
    .luma_in                (luma_in),
    .chroma_in              (chroma_in),
    .valid                  (valid)
  );

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl      <= '0;
      attenuate <= 1'b0;
    end else begin
      ctrl.white_limit_on             <= ~hdelay_peak[vdfc_pkg::WPD_BIT];
      ctrl.gain_update_hysteresis     <= hdelay_peak[5:4];
      ctrl.horizontal_increment_delay <= horizontal_increment_delay_applied;
      ctrl.amp_on                     <= amp_on;
      ctrl.aaf_on                     <= aaf_on;
      ctrl.ch_is_yc                   <= yc;
      ctrl.chroma_follows_luma        <= follow;
      ctrl.luma_input                 <= luma_in;
      ctrl.chroma_input               <= chroma_in;
      ctrl.mode_valid                 <= valid;
      attenuate <= ~hdelay_peak[vdfc_pkg::WPD_BIT]
                   & (luma_level > vdfc_pkg::WHITE_NOMINAL);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  AST_VERSION_READ: assert property (@(posedge core_clk) disable iff (!rst_n)
    req_valid && !req.wr && req.sub == vdfc_pkg::SUB_VERSION |=>
    rdata == {SILICON_REVISION, 4'h0} && rdata_valid)
    else $error("version read wrong");
  AST_WHITE_ENABLE: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_hd |=> ##1 ctrl.white_limit_on == !$past(req.wdata[6], 2))
    else $error("white limit enable wrong");
  AST_ATTENUATE: assert property (@(posedge core_clk) disable iff (!rst_n)
    attenuate |-> ctrl.white_limit_on && $past(luma_level) > 9'h0EB)
    else $error("attenuate without cause");
  AST_HYST: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_hd |=> ##1 ctrl.gain_update_hysteresis == $past(req.wdata[5:4], 2))
    else $error("hysteresis not applied");
  AST_HORIZONTAL_INCREMENT_DELAY_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_hd && req.wdata[3:0] == 4'hF |=> $stable(horizontal_increment_delay_applied))
    else $error("delay changed on hold code");
  AST_ANALOG_FUNCTION_SELECT: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_ai |=> ##1 ctrl.amp_on == $past(req.wdata[7], 2)
      && ctrl.aaf_on == ($past(req.wdata[7:6], 2) == 2'b11))
    else $error("analog function wrong");
  AST_CVBS: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_ai && req.wdata[5:0] <= 6'h05 |=> ##1
      !ctrl.ch_is_yc && ctrl.luma_input == $past(req.wdata[2:0], 2))
    else $error("composite select wrong");
  AST_YC_GAIN: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_ai && req.wdata[5:0] inside {6'h06, 6'h07, 6'h0A, 6'h0B} |=> ##1
      ctrl.ch_is_yc && !ctrl.chroma_follows_luma)
    else $error("programmed chroma gain mode wrong");
  AST_YC_FOLLOW: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_ai && req.wdata[5:0] inside {6'h08, 6'h09, 6'h0C, 6'h0D} |=> ##1
      ctrl.ch_is_yc && ctrl.chroma_follows_luma)
    else $error("following chroma gain mode wrong");
  AST_PAIR: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_ai && req.wdata[5:0] == 6'h0A |=> ##1
      ctrl.luma_input == 3'd6 && ctrl.chroma_input == 3'd4)
    else $error("input pairing wrong");
  AST_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
    !wr_ai |=> $stable(analog_in))
    else $error("register changed without write");

  ////////////////////////////////////////////////////////////////////////////
  // read strobe and holding checks; a stuck strobe would hide read timing
  AST_RDATA_PULSE: assert property (@(posedge core_clk) disable iff (!rst_n)
    1'b1 |-> rdata_valid == $past(req_valid && !req.wr))
    else $error("read strobe wrong");

  AST_UNMAPPED_READ: assert property (@(posedge core_clk) disable iff (!rst_n)
    req_valid && !req.wr && req.sub > vdfc_pkg::SUB_ANALOG_IN |=>
    rdata == 8'h00)
    else $error("unmapped read not zero");

  AST_HD_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
    !wr_hd |=> $stable(hdelay_peak))
    else $error("delay register changed without write");

  AST_HD_TOP_BIT: assert property (@(posedge core_clk) disable iff (!rst_n)
    1'b1 |-> hdelay_peak[7] == 1'b0)
    else $error("unused delay register bit set");

  ////////////////////////////////////////////////////////////////////////////
  // limiter checks, both directions, so a dead comparator is caught; then the delay code load check
  AST_ATTEN_CAUSE: assert property (@(posedge core_clk) disable iff (!rst_n)
    !hdelay_peak[vdfc_pkg::WPD_BIT]
      && luma_level > vdfc_pkg::WHITE_NOMINAL |=> attenuate)
    else $error("attenuate missing");

  AST_ATTEN_OFF: assert property (@(posedge core_clk) disable iff (!rst_n)
    hdelay_peak[vdfc_pkg::WPD_BIT] |=> !attenuate)
    else $error("attenuate while limiting disabled");

  AST_HORIZONTAL_INCREMENT_DELAY_LOAD: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_hd && req.wdata[3:0] != 4'hF |=>
    horizontal_increment_delay_applied == $past(req.wdata[3:0]))
    else $error("delay code not applied");

  ////////////////////////////////////////////////////////////////////////////
  // mode decode checks on the registered control word
  AST_MODE_INVALID: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_ai && req.wdata[5:0] > 6'h0D |=> ##1 !ctrl.mode_valid)
    else $error("later slice mode flagged valid");

  AST_AMP_BYPASS: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_ai && !req.wdata[7] |=> ##1 !ctrl.amp_on && !ctrl.aaf_on)
    else $error("bypass codes not bypassing");

  AST_PAIR_FIRST: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_ai && req.wdata[5:0] inside {6'h06, 6'h08} |=> ##1
      ctrl.luma_input == 3'd0 && ctrl.chroma_input == 3'd2)
    else $error("first pair wrong");

  AST_PAIR_SECOND: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_ai && req.wdata[5:0] inside {6'h07, 6'h09} |=> ##1
      ctrl.luma_input == 3'd1 && ctrl.chroma_input == 3'd3)
    else $error("second pair wrong");

  AST_PAIR_FOURTH: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_ai && req.wdata[5:0] inside {6'h0B, 6'h0D} |=> ##1
      ctrl.luma_input == 3'd7 && ctrl.chroma_input == 3'd5)
    else $error("fourth pair wrong");

  AST_PAIR_THIRD_F: assert property (@(posedge core_clk) disable iff (!rst_n)
    wr_ai && req.wdata[5:0] == 6'h0C |=> ##1
      ctrl.luma_input == 3'd6 && ctrl.chroma_input == 3'd4)
    else $error("third pair wrong");

endmodule : vdfc_front_control_regs

// File: vdfc_host_model.sv
// vdfc_host_model: two-wire host side, one byte access per call
// assumes: register port taken on the rising edge of core_clk
`timescale 1ns/100ps
module vdfc_host_model (
  input  wire logic           core_clk,
  input  wire logic [7:0]     rdata,
  input  wire logic           rdata_valid,
  output vdfc_pkg::vdfc_req_t req,
  output logic                req_valid,
  output logic                timed_out
);
  initial begin
    req = '0;
    req_valid = 1'b0;
    timed_out = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////
  // line noise reduction lives elsewhere, never set here
  // delay codes other than 0111 only when the bench asks
  task automatic access(input logic wr, input logic [7:0] sub,
                        input logic [7:0] wdata, output logic [7:0] rd);
    int n;
    @(posedge core_clk) #1;
    req = '{wr: wr, sub: sub, wdata: wdata};
    if (wr && sub == vdfc_pkg::SUB_HDELAY_PEAK) req.wdata[7] = 1'b0;
    req_valid = 1'b1;
    @(posedge core_clk) #1;
    req_valid = 1'b0;
    req = ~req; // released lines must not look like the old request
    n = 0;
    while (!wr && rdata_valid !== 1'b1 && n < 4) begin
      @(posedge core_clk) #1;
      n++;
    end
    if (n == 4) timed_out = 1'b1;
    rd = rdata;
  endtask : access
endmodule : vdfc_host_model

// File: tb_video_decoder_front_control_regs.sv
// tb_video_decoder_front_control_regs: self-checking bench
// assumes: vdfc_host_model as the only bus master
`timescale 1ns/100ps
module tb_video_decoder_front_control_regs;
  localparam logic [3:0] REV = 4'h5; // arbitrary value
  // {wdata, yc, follow, luma[2:0], chroma[2:0]}
  localparam logic [15:0] ROWS [14] = '{16'h0000, 16'h4108, 16'h8210,
    16'hC318, 16'h0420, 16'h4528, 16'h8682, 16'hC78B, 16'h08C2,
    16'h49CB, 16'h8AB4, 16'hCBBD, 16'h0CF4, 16'h4DFD};
  logic                 core_clk, rst_n, req_valid, rdata_valid;
  logic                 attenuate, timed_out;
  logic [8:0]           luma_level;
  logic [7:0]           rdata, rd;
  vdfc_pkg::vdfc_req_t  req;
  vdfc_pkg::vdfc_ctrl_t ctrl;
  int                   error_cnt, samples_checked;
  vdfc_front_control_regs #(.SILICON_REVISION(REV)) i_vdfc_front_control_regs (
    .core_clk(core_clk), .rst_n(rst_n), .req(req), .req_valid(req_valid),
    .luma_level(luma_level), .rdata(rdata), .rdata_valid(rdata_valid),
    .attenuate(attenuate), .ctrl(ctrl));
  vdfc_host_model i_vdfc_host_model (.core_clk(core_clk), .rdata(rdata),
    .rdata_valid(rdata_valid), .req(req), .req_valid(req_valid),
    .timed_out(timed_out));
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run();
    if (error_cnt == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  task automatic wr(input logic [7:0] sub, input logic [7:0] d);
    i_vdfc_host_model.access(1'b1, sub, d, rd);
    @(posedge core_clk) #1; // ctrl lags the stored byte by one edge
  endtask : wr
  task automatic rdb(input logic [7:0] sub);
    i_vdfc_host_model.access(1'b0, sub, 8'h00, rd);
    chk({7'h00, rdata_valid}, 8'h01);
    if (timed_out) begin
      error_cnt++;
      complete_run();
    end
  endtask : rdb
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    rst_n = 1'b0;
    luma_level = 9'h0EC;
    error_cnt = 0;
    samples_checked = 0;
    repeat (2) @(posedge core_clk);
    #1 rst_n = 1'b1;
    rdb(vdfc_pkg::SUB_VERSION);
    chk(rd, {REV, 4'h0});
    rdb(vdfc_pkg::SUB_HDELAY_PEAK);
    chk(rd, 8'h07);
    chk({ctrl.white_limit_on, 3'h0, ctrl.horizontal_increment_delay}, 8'h87);
    chk({7'h00, attenuate}, 8'h01);
    wr(vdfc_pkg::SUB_VERSION, 8'hA0);
    rdb(vdfc_pkg::SUB_VERSION);
    chk(rd, {REV, 4'h0});
    rdb(8'h05);
    chk(rd, 8'h00);
    foreach (ROWS[i]) begin
      wr(vdfc_pkg::SUB_ANALOG_IN, ROWS[i][15:8]);
      chk({5'h00, ctrl.amp_on, ctrl.aaf_on, ctrl.mode_valid},
          {5'h00, ROWS[i][15], &ROWS[i][15:14], 1'b1});
      chk({ctrl.ch_is_yc, ctrl.chroma_follows_luma, ctrl.luma_input,
           ROWS[i][7] ? ctrl.chroma_input : 3'h0}, ROWS[i][7:0]);
      rdb(vdfc_pkg::SUB_ANALOG_IN);
      chk(rd, ROWS[i][15:8]);
    end
    for (int h = 0; h < 4; h++) begin
      wr(vdfc_pkg::SUB_HDELAY_PEAK, {2'b01, h[1:0], 4'hE});
      chk({ctrl.white_limit_on, 1'b0, ctrl.gain_update_hysteresis,
           ctrl.horizontal_increment_delay}, {4'h0 | h[1:0], 4'hE});
    end
    rdb(vdfc_pkg::SUB_HDELAY_PEAK);
    chk({7'h00, attenuate}, 8'h00);
    wr(vdfc_pkg::SUB_HDELAY_PEAK, 8'h3F);
    chk({ctrl.white_limit_on, 1'b0, ctrl.gain_update_hysteresis,
         ctrl.horizontal_increment_delay}, 8'hBE);
    chk({5'h00, ctrl.luma_input}, 8'h07);
    rdb(vdfc_pkg::SUB_HDELAY_PEAK);
    chk(rd, 8'h3F);
    luma_level = 9'h0EB;
    repeat (2) @(posedge core_clk) #1;
    chk({7'h00, attenuate}, 8'h00);
    wr(vdfc_pkg::SUB_ANALOG_IN, 8'h0E);
    chk({7'h00, ctrl.mode_valid}, 8'h00);
    rst_n = 1'b0;
    #1 chk({7'h00, ctrl !== '0}, 8'h00);
    chk(rdata, 8'h00);
    @(posedge core_clk) #1 rst_n = 1'b1;
    rdb(vdfc_pkg::SUB_ANALOG_IN);
    chk(rd, 8'h00);
    complete_run();
  end
endmodule : tb_video_decoder_front_control_regs
